// *** core/ghra_pkg.sv ***
// Constants for the graphics host register access block
package ghra_pkg;
  localparam int DATA_W     = 16;
  localparam int FIFO_WORDS = 8;
  localparam int PTR_W      = 3;
  localparam int CNT_W      = 4;
  localparam int RAM_WORDS  = 64;
  localparam int PAR_WORDS  = 16;
  localparam int FB_ADDR_W  = 20;
  localparam int MW_W       = 12;
  localparam int START_HI_W = 4;
  localparam int DEPTH_W    = 3;

  // Direct access register numbers
  localparam logic [7:0] REG_FIFO_ENTRY  = 8'h00;
  localparam logic [7:0] REG_CMD_CTRL    = 8'h02;
  localparam logic [7:0] REG_OP_MODE     = 8'h04;
  localparam logic [7:0] REG_DISP_CTRL   = 8'h06;
  localparam logic [7:0] REG_PIXEL_DEPTH = 8'h08;

  // Display control RAM, upper screen first, then base, lower, window
  localparam logic [7:0] REG_UPPER_RASTER            = 8'hC0;
  localparam logic [7:0] REG_BASE_RASTER_ADDRESS     = 8'hC8;
  localparam logic [7:0] REG_BASE_MEMORY_WIDTH       = 8'hCA;
  localparam logic [7:0] REG_BASE_START_ADDRESS      = 8'hCC;
  localparam logic [7:0] REG_LOWER_RASTER_ADDRESS    = 8'hD0;
  localparam logic [7:0] FLD_MEMORY_WIDTH            = 8'h02;
  localparam logic [7:0] FLD_START_HIGH              = 8'h04;
  localparam logic [7:0] FLD_START_LOW               = 8'h06;

  // Field positions
  localparam int CC_ABORT_BIT   = 15;
  localparam int CC_PAUSE_BIT   = 14;
  localparam int DC_ENABLE_LSB  = 12;
  localparam int ST_WF_FULL     = 0;
  localparam int ST_WF_EMPTY    = 1;
  localparam int ST_RF_READY    = 2;
  localparam int ST_RF_FULL     = 3;
  localparam int ST_BUSY        = 4;
  localparam int ST_PAUSED      = 5;
  localparam int PARAM_COLOR    = 0;
  localparam int PARAM_ORIGIN   = 1;

  // Reset values
  localparam logic [15:0] CMD_CTRL_RST    = 16'h0000;
  localparam logic [15:0] OP_MODE_RST     = 16'h0000;
  localparam logic [15:0] DISP_CTRL_RST   = 16'h0000;
  localparam logic [15:0] PIXEL_DEPTH_RST = 16'h0000;
  localparam logic [7:0]  ADDR_RST        = 8'h00;
  localparam logic [18:0] PINS_RST        = 19'h4_0000;

  // Command opcodes in bits 15:12 of a command word
  localparam logic [3:0] PARAM_REG_WRITE_CMD   = 4'h1;
  localparam logic [3:0] PARAM_REG_READ_CMD    = 4'h2;
  localparam logic [3:0] PATTERN_RAM_WRITE_CMD = 4'h3;
  localparam logic [3:0] PATTERN_RAM_READ_CMD  = 4'h4;
  localparam logic [3:0] DOT_CMD               = 4'h5;
endpackage

// *** core/ghra_top.sv ***
// Host port, direct registers, FIFOs and pixel address translation
// Behaviour
// - Frame memory is linear 16-bit words; X-Y becomes word address plus bit offset.
// - Pixel width programmable as 1, 2, 4, 8 or 16 bits.
// - Up to four logical screens map onto frame memory.
// - Per screen start, words per raster and depth, plus one origin shared by all screens, drive translation.
// - Narrow pixels are masked so only their field of the word changes.
// - Host sees two word locations chosen by the port select input.
// - Select-low read returns the status register.
// - Select-low write loads the address register.
// - Select-high access reaches the register named by the address register.
// - FIFO entry register passes host data through read and write FIFOs.
// - Command control holds pause, DMA protocol and interrupt enables; a written abort bit flushes and reads back 0.
// - Operation mode register holds access, priority, skew and scan settings.
// - Display control holds four screen enables and eight attribute bits.
// - Timing control RAM holds sync, display size, period and blink settings.
// - Display control RAM holds per-screen addresses, widths, cursor, zoom, lightpen.
// - Read and write FIFOs each hold sixteen bytes.
// - Commands arrive via write FIFO and move into the command register.
// - After a command completes, the next queued one is fetched automatically.
// - Pattern RAM is reached only by pattern read and write commands.
// - Drawing parameters are reached only by parameter read and write commands.
// - An acknowledge output ends each asynchronous host cycle.
`timescale 1ns/1ps
module ghra_top (
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire logic                             hostCsN,
  input  wire logic                             hostRw,
  input  wire logic                             hostPortSelect,
  input  wire logic [ghra_pkg::DATA_W-1:0]      hostDataIn,
  output logic      [ghra_pkg::DATA_W-1:0]      hostDataOut,
  output logic                                  hostDataOeN,
  output logic                                  transferAckOutN,
  output logic      [3:0]                       screenEnable,
  output logic      [ghra_pkg::FB_ADDR_W-1:0]   fbAddr,
  output logic      [ghra_pkg::DATA_W-1:0]      fbMask,
  output logic      [ghra_pkg::DATA_W-1:0]      fbData,
  output logic                                  fbWrite
);
  typedef enum logic [1:0] {busIdle, busServe, busHold} ghra_bus_t;
  typedef enum logic [1:0] {cmdIdle, cmdArgX, cmdArgY, cmdExec} ghra_cmd_t;
  logic [18:0]                      inSync1_q, inSync2_q;
  ghra_bus_t                        busState_q;
  ghra_cmd_t                        cmdState_q;
  logic [7:0]                       addrReg_q;
  logic [15:0]                      cmdCtrl_q, opMode_q, dispCtrl_q, pixelDepth_q;
  logic                             flush_q;
  logic [15:0]                      ram_q [ghra_pkg::RAM_WORDS];
  logic [15:0]                      param_q [ghra_pkg::PAR_WORDS];
  logic [15:0]                      pattern_q [ghra_pkg::PAR_WORDS];
  logic [15:0]                      wf_q [ghra_pkg::FIFO_WORDS];
  logic [15:0]                      rf_q [ghra_pkg::FIFO_WORDS];
  logic [ghra_pkg::PTR_W-1:0]       wfRd_q, wfWr_q, rfRd_q, rfWr_q;
  logic [ghra_pkg::CNT_W-1:0]       wfCount_q, rfCount_q;
  logic [15:0]                      cmdReg_q, argX_q, argY_q;
  logic [15:0]                      hostDataOut_q, fbMask_q, fbData_q;
  logic                             hostDataOeN_q, ackN_q, fbWrite_q;
  logic [ghra_pkg::FB_ADDR_W-1:0]   fbAddr_q;
  logic        csOn, rdReq, rsReq, fifoEntry, stall, hostDone, hostWr, hostRd;
  logic [15:0] dIn, readValue, status;
  logic        wfEmpty, wfFull, rfEmpty, rfFull, wfPush, wfPop, rfPush, rfPop;
  logic        paused, isRead, hasArg;
  logic [3:0]  opcode;
  logic [15:0] rfData;
  function automatic logic [5:0] ramIdx(input logic [7:0] regNum);
    return regNum[6:1];
  endfunction
  function automatic logic [7:0] scrReg(input logic [1:0] scr, input logic [7:0] fld);
    return 8'(ghra_pkg::REG_UPPER_RASTER + {3'b000, scr, 3'b000} + fld);
  endfunction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inSync1_q <= ghra_pkg::PINS_RST;
      inSync2_q <= ghra_pkg::PINS_RST;
    end else begin
      inSync1_q <= {hostCsN, hostRw, hostPortSelect, hostDataIn};
      inSync2_q <= inSync1_q;
    end
  end
  assign csOn      = !inSync2_q[18];
  assign rdReq     = inSync2_q[17];
  assign rsReq     = inSync2_q[16];
  assign dIn       = inSync2_q[15:0];
  assign wfEmpty   = (wfCount_q == '0);
  assign wfFull    = (wfCount_q == ghra_pkg::CNT_W'(ghra_pkg::FIFO_WORDS));
  assign rfEmpty   = (rfCount_q == '0);
  assign rfFull    = (rfCount_q == ghra_pkg::CNT_W'(ghra_pkg::FIFO_WORDS));
  assign fifoEntry = rsReq && (addrReg_q == ghra_pkg::REG_FIFO_ENTRY);
  assign stall     = fifoEntry && (rdReq ? rfEmpty : wfFull);
  assign hostDone  = (busState_q == busServe) && !stall;
  assign hostWr    = hostDone && !rdReq;
  assign hostRd    = hostDone && rdReq;
  assign paused    = cmdCtrl_q[ghra_pkg::CC_PAUSE_BIT];
  assign rfData    = rf_q[rfRd_q];
  always_comb begin
    status = '0;
    status[ghra_pkg::ST_WF_FULL]  = wfFull;
    status[ghra_pkg::ST_WF_EMPTY] = wfEmpty;
    status[ghra_pkg::ST_RF_READY] = !rfEmpty;
    status[ghra_pkg::ST_RF_FULL]  = rfFull;
    status[ghra_pkg::ST_BUSY]     = (cmdState_q != cmdIdle) || !wfEmpty;
    status[ghra_pkg::ST_PAUSED]   = paused;
  end
  always_comb begin
    readValue = '0;
    if (!rsReq) begin
      readValue = status;
    end else if (addrReg_q[7]) begin
      readValue = ram_q[ramIdx(addrReg_q)];
    end else begin
      unique case (addrReg_q)
        ghra_pkg::REG_FIFO_ENTRY:  readValue = rfData;
        ghra_pkg::REG_CMD_CTRL:    readValue = cmdCtrl_q;
        ghra_pkg::REG_OP_MODE:     readValue = opMode_q;
        ghra_pkg::REG_DISP_CTRL:   readValue = dispCtrl_q;
        ghra_pkg::REG_PIXEL_DEPTH: readValue = pixelDepth_q;
        default:                   readValue = '0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_q    <= busIdle;
      ackN_q        <= 1'b1;
      hostDataOeN_q <= 1'b1;
      hostDataOut_q <= '0;
    end else begin
      unique case (busState_q)
        busIdle: if (csOn) busState_q <= busServe;
        busServe: if (!stall) begin
          busState_q    <= busHold;
          ackN_q        <= 1'b0;
          hostDataOeN_q <= !rdReq;
          if (rdReq) hostDataOut_q <= readValue;
        end
        busHold: if (!csOn) begin
          busState_q    <= busIdle;
          ackN_q        <= 1'b1;
          hostDataOeN_q <= 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) addrReg_q <= ghra_pkg::ADDR_RST;
    else if (hostWr && !rsReq) addrReg_q <= dIn[7:0];
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdCtrl_q    <= ghra_pkg::CMD_CTRL_RST;
      opMode_q     <= ghra_pkg::OP_MODE_RST;
      dispCtrl_q   <= ghra_pkg::DISP_CTRL_RST;
      pixelDepth_q <= ghra_pkg::PIXEL_DEPTH_RST;
      flush_q      <= 1'b0;
    end else begin
      flush_q <= hostWr && rsReq && (addrReg_q == ghra_pkg::REG_CMD_CTRL) && dIn[ghra_pkg::CC_ABORT_BIT];
      if (hostWr && rsReq) begin
        unique case (addrReg_q)
          ghra_pkg::REG_CMD_CTRL: begin
            cmdCtrl_q <= dIn;
            cmdCtrl_q[ghra_pkg::CC_ABORT_BIT] <= 1'b0;
          end
          ghra_pkg::REG_OP_MODE:     opMode_q     <= dIn;
          ghra_pkg::REG_DISP_CTRL:   dispCtrl_q   <= dIn;
          ghra_pkg::REG_PIXEL_DEPTH: pixelDepth_q <= dIn;
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ghra_pkg::RAM_WORDS; i++) ram_q[i] <= '0;
    end else if (hostWr && rsReq && addrReg_q[7]) begin
      ram_q[ramIdx(addrReg_q)] <= dIn;
    end
  end
  assign wfPush = hostWr && fifoEntry;
  assign rfPop  = hostRd && fifoEntry;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wfRd_q <= '0;
      wfWr_q <= '0;
      wfCount_q <= '0;
    end else if (flush_q) begin
      wfRd_q <= '0;
      wfWr_q <= '0;
      wfCount_q <= '0;
    end else begin
      if (wfPush) begin
        wf_q[wfWr_q] <= dIn;
        wfWr_q <= wfWr_q + 1'b1;
      end
      if (wfPop) wfRd_q <= wfRd_q + 1'b1;
      wfCount_q <= wfCount_q + {3'b000, wfPush} - {3'b000, wfPop};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rfRd_q <= '0;
      rfWr_q <= '0;
      rfCount_q <= '0;
    end else if (flush_q) begin
      rfRd_q <= '0;
      rfWr_q <= '0;
      rfCount_q <= '0;
    end else begin
      if (rfPush) begin
        rf_q[rfWr_q] <= (opcode == ghra_pkg::PARAM_REG_READ_CMD) ? param_q[cmdReg_q[3:0]]
                                                                 : pattern_q[cmdReg_q[3:0]];
        rfWr_q <= rfWr_q + 1'b1;
      end
      if (rfPop) rfRd_q <= rfRd_q + 1'b1;
      rfCount_q <= rfCount_q + {3'b000, rfPush} - {3'b000, rfPop};
    end
  end
  assign opcode = cmdReg_q[15:12];
  assign isRead = (opcode == ghra_pkg::PARAM_REG_READ_CMD) || (opcode == ghra_pkg::PATTERN_RAM_READ_CMD);
  assign hasArg = (opcode == ghra_pkg::PARAM_REG_WRITE_CMD) || (opcode == ghra_pkg::PATTERN_RAM_WRITE_CMD)
               || (opcode == ghra_pkg::DOT_CMD);
  assign wfPop  = ((cmdState_q == cmdArgX) ? hasArg : (cmdState_q != cmdExec)) && !wfEmpty && !paused && !flush_q;
  assign rfPush = (cmdState_q == cmdExec) && isRead && !rfFull && !flush_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdState_q <= cmdIdle;
      cmdReg_q   <= '0;
      argX_q     <= '0;
      argY_q     <= '0;
    end else if (flush_q) begin
      cmdState_q <= cmdIdle;
    end else begin
      unique case (cmdState_q)
        cmdIdle: if (wfPop) begin
          cmdReg_q   <= wf_q[wfRd_q];
          cmdState_q <= cmdArgX;
        end
        cmdArgX: if (!hasArg) begin
          cmdState_q <= cmdExec;
        end else if (wfPop) begin
          argX_q     <= wf_q[wfRd_q];
          cmdState_q <= (opcode == ghra_pkg::DOT_CMD) ? cmdArgY : cmdExec;
        end
        cmdArgY: if (wfPop) begin
          argY_q     <= wf_q[wfRd_q];
          cmdState_q <= cmdExec;
        end
        cmdExec: if (!isRead || rfPush) cmdState_q <= cmdIdle;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ghra_pkg::PAR_WORDS; i++) begin
        param_q[i]   <= '0;
        pattern_q[i] <= '0;
      end
    end else if (cmdState_q == cmdExec && !flush_q) begin
      if (opcode == ghra_pkg::PARAM_REG_WRITE_CMD) param_q[cmdReg_q[3:0]] <= argX_q;
      if (opcode == ghra_pkg::PATTERN_RAM_WRITE_CMD) pattern_q[cmdReg_q[3:0]] <= argX_q;
    end
  end
  logic [1:0]  scr;
  logic [2:0]  depth, shiftPix;
  logic [31:0] wordInRow, pixInWord, fieldMask, startAddr, rowOff, sum;
  logic [15:0] pixMask;
  logic [4:0]  pixBits;
  always_comb begin
    scr       = cmdReg_q[9:8];
    depth     = pixelDepth_q[{scr, 2'b00} +: ghra_pkg::DEPTH_W] > 3'h4 ? 3'h4
              : pixelDepth_q[{scr, 2'b00} +: ghra_pkg::DEPTH_W];
    shiftPix  = 3'(3'd4 - depth);
    pixBits   = 5'(5'd1 << depth);
    wordInRow = 32'(argX_q) >> shiftPix;
    pixInWord = 32'(argX_q) & ((32'd1 << shiftPix) - 32'd1);
    fieldMask = (32'd1 << pixBits) - 32'd1;
    pixMask   = 16'(fieldMask << (pixInWord << depth));
    startAddr = {12'h000, ram_q[ramIdx(scrReg(scr, ghra_pkg::FLD_START_HIGH))][ghra_pkg::START_HI_W-1:0],
                 ram_q[ramIdx(scrReg(scr, ghra_pkg::FLD_START_LOW))]};
    rowOff    = 32'(argY_q) * 32'(ram_q[ramIdx(scrReg(scr, ghra_pkg::FLD_MEMORY_WIDTH))][ghra_pkg::MW_W-1:0]);
    sum       = startAddr + 32'(param_q[ghra_pkg::PARAM_ORIGIN]) + rowOff + wordInRow;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fbWrite_q <= 1'b0;
      fbAddr_q  <= '0;
      fbMask_q  <= '0;
      fbData_q  <= '0;
    end else begin
      fbWrite_q <= (cmdState_q == cmdExec) && (opcode == ghra_pkg::DOT_CMD) && !flush_q
                && dispCtrl_q[ghra_pkg::DC_ENABLE_LSB + 32'(scr)];
      if (cmdState_q == cmdExec && opcode == ghra_pkg::DOT_CMD) begin
        fbAddr_q <= sum[ghra_pkg::FB_ADDR_W-1:0];
        fbMask_q <= pixMask;
        fbData_q <= param_q[ghra_pkg::PARAM_COLOR] & pixMask;
      end
    end
  end
  assign hostDataOut     = hostDataOut_q;
  assign hostDataOeN     = hostDataOeN_q;
  assign transferAckOutN = ackN_q;
  assign screenEnable    = dispCtrl_q[ghra_pkg::DC_ENABLE_LSB +: 4];
  assign fbAddr          = fbAddr_q;
  assign fbMask          = fbMask_q;
  assign fbData          = fbData_q;
  assign fbWrite         = fbWrite_q;
  sequence hostServed;
    busState_q == busServe && !stall;
  endsequence
  sequence ackHeldLow;
    !ackN_q ##1 !ackN_q;
  endsequence
  a_ack_holds_cs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostServed |=> ackHeldLow) else $error("ack not held after service");
  a_ack_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ackN_q) |-> !$past(csOn)) else $error("ack released while selected");
  a_addr_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostWr && !rsReq |=> addrReg_q == $past(dIn[7:0])) else $error("address register not loaded");
  a_addr_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(hostWr && !rsReq) |=> $stable(addrReg_q)) else $error("address register changed");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostRd && !rsReq |=> hostDataOut_q == $past(status) && !hostDataOeN_q) else $error("status not returned");
  a_ram_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostWr && rsReq && addrReg_q[7] |=> ram_q[ramIdx(addrReg_q)] == $past(dIn))
    else $error("direct register not written");
  a_fifo_depth: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wfCount_q <= 4'h8 && rfCount_q <= 4'h8) else $error("fifo over depth");
  a_cmd_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmdState_q == cmdIdle && wfPop |=> cmdState_q == cmdArgX && cmdReg_q == $past(wf_q[wfRd_q]))
    else $error("queued command not fetched");
  a_dot_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fbWrite_q |-> $countones(fbMask_q) == 32'($past(pixBits)) && (fbData_q & ~fbMask_q) == '0)
    else $error("pixel mask wrong width");
endmodule

// *** dv/ghra_host_model.sv ***
// Host bus master model driving the two-location register port
`timescale 1ns/1ps
module ghra_host_model (
  input  wire logic        sys_clk,
  input  wire logic        ackN,
  input  wire logic [15:0] dataOut,
  output logic             csN,
  output logic             rw,
  output logic             portSelect,
  output logic [15:0]      dataIn
);
  initial begin
    csN = 1'b1;
    rw = 1'b1;
    portSelect = 1'b0;
    dataIn = 16'h0000;
  end

  // One host cycle: hold until ack, take data at that edge, release
  task automatic access(input logic hostAddr, input logic isRead, input logic [15:0] wData,
                        output logic [15:0] rData, output bit ok);
    int n;
    ok = 1'b0;
    rData = 16'h0000;
    @(posedge sys_clk);
    portSelect <= hostAddr;
    rw <= isRead;
    dataIn <= wData;
    csN <= 1'b0;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk);
      if (ackN === 1'b0) begin
        rData = dataOut;
        ok = 1'b1;
        break;
      end
    end
    csN <= 1'b1;
    dataIn <= ~wData;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk);
      if (ackN === 1'b1) break;
    end
    if (ackN !== 1'b1) ok = 1'b0;
  endtask
endmodule

// *** dv/tb_graphics_host_register_access.sv ***
// Self-checking bench for the graphics host register access block
`timescale 1ns/1ps
module tb_graphics_host_register_access;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        csN, rw, ps, oeN, ackN, fbWrite;
  logic [15:0] dIn, dOut, fbMask, fbData, lastMask, lastData;
  logic [3:0]  scrEn;
  logic [19:0] fbAddr, lastAddr;
  int          errCount = 0;
  int          testsRun = 0;
  int          dotCount = 0;

  always #12.5 sys_clk = ~sys_clk;

  ghra_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hostCsN(csN), .hostRw(rw), .hostPortSelect(ps),
    .hostDataIn(dIn), .hostDataOut(dOut), .hostDataOeN(oeN), .transferAckOutN(ackN), .screenEnable(scrEn),
    .fbAddr(fbAddr), .fbMask(fbMask), .fbData(fbData), .fbWrite(fbWrite));
  ghra_host_model host (.sys_clk(sys_clk), .ackN(ackN), .dataOut(dOut), .csN(csN), .rw(rw),
    .portSelect(ps), .dataIn(dIn));

  // Capture every dot write pulse
  always @(negedge sys_clk) begin
    if (fbWrite === 1'b1) begin
      dotCount++;
      lastAddr = fbAddr;
      lastMask = fbMask;
      lastData = fbData;
    end
  end

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic hostOp(input logic sel, input logic isRead, input logic [15:0] wData, output logic [15:0] rData);
    bit ok;
    host.access(sel, isRead, wData, rData, ok);
    if (!ok) begin
      errCount++;
      $display("[FAIL] host acknowledge expected 0 seen 1");
      testDone();
    end
  endtask

  task automatic regWr(input logic [7:0] num, input logic [15:0] d);
    logic [15:0] q;
    hostOp(1'b0, 1'b0, {8'h00, num}, q);
    hostOp(1'b1, 1'b0, d, q);
  endtask

  task automatic regRd(input logic [7:0] num, input logic [15:0] exp, input string name);
    logic [15:0] q;
    hostOp(1'b0, 1'b0, {8'h00, num}, q);
    hostOp(1'b1, 1'b1, 16'h0000, q);
    check(name, {16'h0000, exp}, {16'h0000, q});
    hostOp(1'b1, 1'b1, 16'h0000, q);
    check(name, {16'h0000, exp}, {16'h0000, q});
  endtask

  task automatic statRd(input logic [15:0] exp);
    logic [15:0] q;
    hostOp(1'b0, 1'b1, 16'h0000, q);
    check("status", {16'h0000, exp}, {16'h0000, q});
  endtask

  task automatic fifoRd(input logic [15:0] exp, input string name);
    logic [15:0] q;
    hostOp(1'b0, 1'b0, {8'h00, ghra_pkg::REG_FIFO_ENTRY}, q);
    hostOp(1'b1, 1'b1, 16'h0000, q);
    check(name, {16'h0000, exp}, {16'h0000, q});
  endtask

  task automatic push(input logic [15:0] d);
    regWr(ghra_pkg::REG_FIFO_ENTRY, d);
  endtask

  task automatic waitDots(input int n);
    int i;
    for (i = 0; i < 400 && dotCount < n; i++) @(posedge sys_clk);
    if (dotCount < n) begin
      errCount++;
      $display("[FAIL] dot pulses expected %0d seen %0d", n, dotCount);
      testDone();
    end
  endtask

  task automatic checkDot(input int d, input int x);
    int bpp;
    logic [15:0] mask;
    bpp = 1 << d;
    mask = 16'((32'h1 << bpp) - 1) << ((x % (16 >> d)) * bpp);
    check("fbAddr", 32'h1_0100 + 32'h0010 + 3 * 40 + (x >> (4 - d)), {12'h000, lastAddr});
    check("fbMask", {16'h0000, mask}, {16'h0000, lastMask});
    check("fbData", {16'h0000, 16'hB6D9 & mask}, {16'h0000, lastData});
  endtask

  task automatic testReset();
    statRd(16'h0002);
    check("screenEnable", 32'h0, {28'h0, scrEn});
    check("hostDataOeN", 32'h1, {31'h0, oeN});
    regRd(ghra_pkg::REG_CMD_CTRL, ghra_pkg::CMD_CTRL_RST, "cmdCtrl");
    regRd(ghra_pkg::REG_DISP_CTRL, ghra_pkg::DISP_CTRL_RST, "dispCtrl");
    $display("test reset done");
  endtask

  task automatic testDirect();
    logic [7:0]  nums [8] = '{ghra_pkg::REG_CMD_CTRL, ghra_pkg::REG_OP_MODE, ghra_pkg::REG_DISP_CTRL,
      ghra_pkg::REG_PIXEL_DEPTH, ghra_pkg::REG_BASE_RASTER_ADDRESS, ghra_pkg::REG_BASE_MEMORY_WIDTH,
      ghra_pkg::REG_BASE_START_ADDRESS, ghra_pkg::REG_LOWER_RASTER_ADDRESS};
    logic [15:0] vals [8] = '{16'h0123, 16'hA5C3, 16'hC3A5, 16'h0421, 16'h1234, 16'h00AB, 16'h0009, 16'h4321};
    for (int i = 0; i < 8; i++) regWr(nums[i], vals[i]);
    for (int i = 0; i < 8; i++) regRd(nums[i], vals[i], "directReg");
    check("screenEnable", 32'hC, {28'h0, scrEn});
    regWr(8'h0A, 16'hFFFF);
    regRd(8'h0A, 16'h0000, "unmapped");
    statRd(16'h0002);
    $display("test direct done");
  endtask

  task automatic testDot();
    regWr(ghra_pkg::REG_DISP_CTRL, 16'hF000);
    regWr(ghra_pkg::REG_BASE_MEMORY_WIDTH, 16'h0028);
    regWr(ghra_pkg::REG_BASE_START_ADDRESS, 16'h0001);
    regWr(ghra_pkg::REG_BASE_RASTER_ADDRESS + ghra_pkg::FLD_START_LOW, 16'h0100);
    push(16'h1000);
    push(16'hB6D9);
    push(16'h1001);
    push(16'h0010);
    for (int d = 0; d < 5; d++) begin
      regWr(ghra_pkg::REG_PIXEL_DEPTH, 16'(d << 4));
      push(16'h5100);
      push(16'd37);
      push(16'd3);
      waitDots(d + 1);
      checkDot(d, 37);
    end
    push(16'h5100);
    push(16'd37);
    push(16'd3);
    push(16'h5100);
    push(16'd38);
    push(16'd3);
    waitDots(7);
    checkDot(4, 38);
    push(16'h5000);
    push(16'd37);
    push(16'd3);
    waitDots(8);
    check("upperAddr", 32'h0000_0012, {12'h000, lastAddr});
    check("upperMask", 32'h0000_0020, {16'h0000, lastMask});
    regWr(ghra_pkg::REG_DISP_CTRL, 16'h0000);
    push(16'h5100);
    push(16'd1);
    push(16'd1);
    repeat (40) @(posedge sys_clk);
    check("dotCount", 32'd8, dotCount);
    $display("test dot done");
  endtask

  task automatic testAccessCmds();
    push(16'h3000);
    push(16'h9A5E);
    push(16'h4000);
    fifoRd(16'h9A5E, "patternRead");
    statRd(16'h0002);
    push(16'h1002);
    push(16'h7E81);
    push(16'h2002);
    fifoRd(16'h7E81, "paramRead");
    statRd(16'h0002);
    $display("test access commands done");
  endtask

  task automatic testFifo();
    regWr(ghra_pkg::REG_CMD_CTRL, 16'h4000);
    for (int i = 0; i < 8; i++) push(16'h0000);
    statRd(16'h0031);
    regWr(ghra_pkg::REG_CMD_CTRL, 16'h8000);
    regRd(ghra_pkg::REG_CMD_CTRL, 16'h0000, "cmdCtrl");
    statRd(16'h0002);
    $display("test fifo done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    testReset();
    testDirect();
    testDot();
    testAccessCmds();
    testFifo();
    testDone();
  end
endmodule
